// *** logic/itm_defines.svh ***
`ifndef ITM_DEFINES_SVH
`define ITM_DEFINES_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define ITM_OFS_CTRL      4'h0
`define ITM_OFS_STS       4'h1
`define ITM_OFS_MASK      4'h2
`define ITM_OFS_SLVCTL    4'h3

// ----------------------------------------
// Field positions
// ----------------------------------------
`define ITM_CTRL_EN_BIT   7
`define ITM_CTRL_FLAG_BIT 6
`define ITM_CTRL_SEL_MSB  5
`define ITM_CTRL_SEL_LSB  0
`define ITM_STS_TO_BIT    0
`define ITM_STS_START_BIT 1

// ----------------------------------------
// Reset values
// ----------------------------------------
`define ITM_CTRL_RST      8'h00
`define ITM_SLVCTL_POR    8'h00
`define ITM_IRQ_RST       2'h0
`define ITM_PIN_RST       3'h7
`define ITM_SUB_RST       3'h0
`define ITM_RDATA_IDLE    8'h00

// ----------------------------------------
// Timing
// ----------------------------------------
`define ITM_SUB_DIV       32
`define ITM_DIV_W         5

`endif

// *** logic/itm_pkg.sv ***
package itm_pkg;

    // ----------------------------------------
    // Monitor states
    // ----------------------------------------
    typedef enum logic [1:0] {
        ITM_IDLE,
        ITM_ARMED,
        ITM_RUN
    } itm_state_t;

    // ----------------------------------------
    // Monitor state record
    // ----------------------------------------
    typedef struct packed {
        itm_state_t  state;
        logic [5:0]  count;
        logic        en;
        logic        flag;
        logic [5:0]  sel;
        logic [1:0]  sts;
        logic [1:0]  mask;
        logic [7:0]  slv_ctl;
        logic [7:0]  rdata;
        logic [2:0]  scl_sync;
        logic [2:0]  sda_sync;
        logic        scl_q;
        logic        sda_q;
        logic        slave_rst;
    } itm_mon_t;

    // ----------------------------------------
    // Divider state record
    // ----------------------------------------
    typedef struct packed {
        logic [2:0]  sync;
        logic        lvl;
        logic [4:0]  cnt;
        logic        tick;
    } itm_div_t;

endpackage

// *** logic/itm_sub_tick.sv ***
`include "itm_defines.svh"

module itm_sub_tick #(
    parameter int DIV = `ITM_SUB_DIV
) (
    // Clock and reset
    input  wire logic  mclk,
    input  wire logic  reset,
    // Subsystem clock pin
    input  wire logic  sub_clk_in,
    // Tick link to the monitor
    itm_tick_if.div    tk
);

    localparam logic [`ITM_DIV_W-1:0] CNT_LAST = `ITM_DIV_W'(DIV - 1);

    itm_pkg::itm_div_t s_ff;
    itm_pkg::itm_div_t nxt_s;
    logic              lvl_new;

    // ----------------------------------------
    // Slow clock sampled as a pin
    // ----------------------------------------
    // Only the second and third stages are compared; the first may be metastable
    assign lvl_new = (s_ff.sync[1] == s_ff.sync[2]) ? s_ff.sync[2] : s_ff.lvl;

    always_comb begin
        nxt_s      = s_ff;
        nxt_s.sync = {s_ff.sync[1:0], sub_clk_in};
        nxt_s.lvl  = lvl_new;
        nxt_s.tick = 1'b0;
        if (tk.clr) begin
            nxt_s.cnt = '0;
        end else if (!s_ff.lvl && lvl_new) begin
            if (s_ff.cnt == CNT_LAST) begin
                nxt_s.cnt  = '0;
                nxt_s.tick = 1'b1;
            end else begin
                nxt_s.cnt = s_ff.cnt + `ITM_DIV_W'(1);
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            s_ff      <= '0;
            s_ff.sync <= `ITM_SUB_RST;
        end else begin
            s_ff <= nxt_s;
        end
    end

    assign tk.tick = s_ff.tick;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    tick_div_a: assert property (
        @(posedge mclk) disable iff (reset)
        tk.tick |-> ($past(s_ff.cnt) == CNT_LAST) && !$past(tk.clr)
                    && s_ff.lvl && !$past(s_ff.lvl)
    ) else $error("tick without a full divide count");

endmodule

// *** logic/itm_tick_if.sv ***
interface itm_tick_if;
    logic clr;
    logic tick;

    modport mon (
        output clr,
        input  tick
    );

    modport div (
        input  clr,
        output tick
    );
endinterface

// *** logic/itm_timeout_monitor.sv ***
`include "itm_defines.svh"

// Summary of operation
// - Start counting after START plus address match
// - Each SCL falling edge clears the counter
// - No falling edge within period means time-out
// - STOP ends the time-out function
// - Overflow halts counter, clears enable, sets flag
// - Time-out raises the shared serial interrupt
// - Time-out resets slave logic to idle
// - Slave status control reverts; other registers kept
// - Flag stays set until software clears it
// - Counter clocked by subsystem clock over 32
// - Period is (select plus one) times 32
// - Six-bit select gives 64 period lengths
// - Enable bit seven gates the whole function
module itm_timeout_monitor (
    // Clock and reset
    input  wire logic        mclk,
    input  wire logic        reset,
    // Bus pins, sampled only
    input  wire logic        scl_in,
    input  wire logic        sda_in,
    // Subsystem clock pin
    input  wire logic        sub_clk_in,
    // From the slave engine
    input  wire logic        addr_match,
    // Register port
    input  wire logic [3:0]  addr,
    input  wire logic [7:0]  wdata,
    input  wire logic        wr_strobe,
    input  wire logic        rd_strobe,
    output logic      [7:0]  rdata,
    // To the slave engine and system
    output logic             slave_reset,
    output logic      [7:0]  slave_status_control,
    output logic             timeout_active,
    output logic             irq
);

    itm_pkg::itm_mon_t s_ff;
    itm_pkg::itm_mon_t nxt_s;

    logic        scl_new;
    logic        sda_new;
    logic        scl_fall;
    logic        start_det;
    logic        stop_det;
    logic        ctl_wr;
    logic        sts_wr;
    logic        mask_wr;
    logic        slv_wr;
    logic        timeout_now;
    logic [7:0]  rd_mux;

    itm_tick_if tk ();

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic logic reg_hit(input logic [3:0] a, input logic [3:0] ofs);
        reg_hit = (a == ofs);
    endfunction

    // A pin level is taken only when the second and third stages agree
    function automatic logic pin_filt(input logic [2:0] sync, input logic prev);
        pin_filt = (sync[1] == sync[2]) ? sync[2] : prev;
    endfunction

    // ----------------------------------------
    // Divider for the counter clock
    // ----------------------------------------
    itm_sub_tick #(
        .DIV (`ITM_SUB_DIV)
    ) u_div (
        .mclk       (mclk),
        .reset      (reset),
        .sub_clk_in (sub_clk_in),
        .tk         (tk.div)
    );

    // ----------------------------------------
    // Bus condition detection
    // ----------------------------------------
    assign scl_new   = pin_filt(s_ff.scl_sync, s_ff.scl_q);
    assign sda_new   = pin_filt(s_ff.sda_sync, s_ff.sda_q);
    assign scl_fall  = s_ff.scl_q && !scl_new;
    // SDA falling with SCL high on both sides of the change
    assign start_det = s_ff.scl_q && scl_new && s_ff.sda_q && !sda_new;
    assign stop_det  = s_ff.scl_q && scl_new && !s_ff.sda_q && sda_new;

    // ----------------------------------------
    // Register decode
    // ----------------------------------------
    assign ctl_wr  = wr_strobe && reg_hit(addr, `ITM_OFS_CTRL);
    assign sts_wr  = wr_strobe && reg_hit(addr, `ITM_OFS_STS);
    assign mask_wr = wr_strobe && reg_hit(addr, `ITM_OFS_MASK);
    assign slv_wr  = wr_strobe && reg_hit(addr, `ITM_OFS_SLVCTL);

    always_comb begin
        rd_mux = `ITM_RDATA_IDLE;
        if (reg_hit(addr, `ITM_OFS_CTRL)) begin
            rd_mux = {s_ff.en, s_ff.flag, s_ff.sel};
        end else if (reg_hit(addr, `ITM_OFS_STS)) begin
            rd_mux = {6'h00, s_ff.sts};
        end else if (reg_hit(addr, `ITM_OFS_MASK)) begin
            rd_mux = {6'h00, s_ff.mask};
        end else if (reg_hit(addr, `ITM_OFS_SLVCTL)) begin
            rd_mux = s_ff.slv_ctl;
        end
    end

    // ----------------------------------------
    // Expiry
    // ----------------------------------------
    // A falling edge or STOP in the expiry cycle still rescues the transfer
    assign timeout_now = s_ff.en && (s_ff.state == itm_pkg::ITM_RUN)
                      && !stop_det && !scl_fall && tk.tick
                      && (s_ff.count == s_ff.sel);

    // Divider restarts with each falling edge so the period is measured from it
    assign tk.clr = (s_ff.state != itm_pkg::ITM_RUN) || scl_fall || !s_ff.en;

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always_comb begin
        nxt_s           = s_ff;
        nxt_s.scl_sync  = {s_ff.scl_sync[1:0], scl_in};
        nxt_s.sda_sync  = {s_ff.sda_sync[1:0], sda_in};
        nxt_s.scl_q     = scl_new;
        nxt_s.sda_q     = sda_new;
        nxt_s.slave_rst = 1'b0;
        nxt_s.rdata     = rd_strobe ? rd_mux : `ITM_RDATA_IDLE;

        if (ctl_wr) begin
            nxt_s.en   = wdata[`ITM_CTRL_EN_BIT];
            nxt_s.flag = wdata[`ITM_CTRL_FLAG_BIT];
            nxt_s.sel  = wdata[`ITM_CTRL_SEL_MSB:`ITM_CTRL_SEL_LSB];
        end
        if (sts_wr) begin
            nxt_s.sts = s_ff.sts & ~wdata[1:0];
        end
        if (mask_wr) begin
            nxt_s.mask = wdata[1:0];
        end
        if (slv_wr) begin
            nxt_s.slv_ctl = wdata;
        end
        if (start_det) begin
            nxt_s.sts[`ITM_STS_START_BIT] = 1'b1;
        end

        case (s_ff.state)
            itm_pkg::ITM_IDLE: begin
                if (start_det) begin
                    nxt_s.state = itm_pkg::ITM_ARMED;
                end
            end
            itm_pkg::ITM_ARMED: begin
                if (stop_det) begin
                    nxt_s.state = itm_pkg::ITM_IDLE;
                end else if (addr_match) begin
                    nxt_s.state = itm_pkg::ITM_RUN;
                    nxt_s.count = '0;
                end
            end
            itm_pkg::ITM_RUN: begin
                if (stop_det) begin
                    nxt_s.state = itm_pkg::ITM_IDLE;
                    nxt_s.count = '0;
                end else if (scl_fall) begin
                    nxt_s.count = '0;
                end else if (tk.tick && (s_ff.count != s_ff.sel)) begin
                    nxt_s.count = s_ff.count + 6'h01;
                end
            end
            default: begin
                nxt_s.state = itm_pkg::ITM_IDLE;
            end
        endcase

        // Disabled: nothing runs, nothing arms
        if (!s_ff.en) begin
            nxt_s.state = itm_pkg::ITM_IDLE;
            nxt_s.count = '0;
        end

        // Hardware wins over a software write in the same cycle
        if (timeout_now) begin
            nxt_s.state                = itm_pkg::ITM_IDLE;
            nxt_s.count                = '0;
            nxt_s.en                   = 1'b0;
            nxt_s.flag                 = 1'b1;
            nxt_s.sts[`ITM_STS_TO_BIT] = 1'b1;
            nxt_s.slv_ctl              = `ITM_SLVCTL_POR;
            nxt_s.slave_rst            = 1'b1;
        end
    end

    // ----------------------------------------
    // State register
    // ----------------------------------------
    always_ff @(posedge mclk) begin
        if (reset) begin
            s_ff                      <= '0;
            {s_ff.en, s_ff.flag, s_ff.sel} <= `ITM_CTRL_RST;
            s_ff.sts                  <= `ITM_IRQ_RST;
            s_ff.mask                 <= `ITM_IRQ_RST;
            s_ff.slv_ctl              <= `ITM_SLVCTL_POR;
            s_ff.rdata                <= `ITM_RDATA_IDLE;
            s_ff.scl_sync             <= `ITM_PIN_RST;
            s_ff.sda_sync             <= `ITM_PIN_RST;
            s_ff.scl_q                <= 1'b1;
            s_ff.sda_q                <= 1'b1;
        end else begin
            s_ff <= nxt_s;
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    assign rdata                = s_ff.rdata;
    assign slave_reset          = s_ff.slave_rst;
    assign slave_status_control = s_ff.slv_ctl;
    assign timeout_active       = (s_ff.state == itm_pkg::ITM_RUN);
    assign irq                  = |(s_ff.sts & s_ff.mask);

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    arm_run_a: assert property (
        @(posedge mclk) disable iff (reset)
        (s_ff.state == itm_pkg::ITM_ARMED) && addr_match && s_ff.en && !stop_det
        |=> (s_ff.state == itm_pkg::ITM_RUN) && (s_ff.count == 6'h00)
    ) else $error("match after START did not start the counter");

    fall_clear_a: assert property (
        @(posedge mclk) disable iff (reset)
        (s_ff.state == itm_pkg::ITM_RUN) && scl_fall && s_ff.en
        |=> (s_ff.count == 6'h00) && !s_ff.flag || $past(s_ff.flag)
    ) else $error("SCL falling edge did not clear the counter");

    expire_a: assert property (
        @(posedge mclk) disable iff (reset)
        (s_ff.state == itm_pkg::ITM_RUN) && s_ff.en && tk.tick && !scl_fall
        && !stop_det && (s_ff.count == s_ff.sel)
        |=> s_ff.flag && !s_ff.en && (s_ff.state == itm_pkg::ITM_IDLE)
    ) else $error("expiry did not flag, disable and halt");

    stop_end_a: assert property (
        @(posedge mclk) disable iff (reset)
        (s_ff.state == itm_pkg::ITM_RUN) && stop_det
        |=> (s_ff.state == itm_pkg::ITM_IDLE) && !$rose(s_ff.flag)
    ) else $error("STOP did not end the time-out function");

    halt_after_a: assert property (
        @(posedge mclk) disable iff (reset)
        $rose(s_ff.flag) && !$past(ctl_wr)
        |-> !s_ff.en && (s_ff.count == 6'h00) ##1 (s_ff.state != itm_pkg::ITM_RUN)
    ) else $error("counter still armed after overflow");

    irq_level_a: assert property (
        @(posedge mclk) disable iff (reset)
        $past(timeout_now) && s_ff.mask[`ITM_STS_TO_BIT] |-> irq
    ) else $error("time-out did not raise the interrupt");

    slave_rst_a: assert property (
        @(posedge mclk) disable iff (reset)
        timeout_now |=> slave_reset && (slave_status_control == `ITM_SLVCTL_POR)
                        ##1 !slave_reset
    ) else $error("time-out did not reset the slave state");

    flag_hold_a: assert property (
        @(posedge mclk) disable iff (reset)
        s_ff.flag && !ctl_wr |=> s_ff.flag
    ) else $error("time-out flag dropped without software");

    count_range_a: assert property (
        @(posedge mclk) disable iff (reset)
        (s_ff.state == itm_pkg::ITM_RUN) |-> (s_ff.count <= s_ff.sel)
    ) else $error("counter passed the selected period");

    disabled_a: assert property (
        @(posedge mclk) disable iff (reset)
        !s_ff.en && !ctl_wr
        |=> (s_ff.state == itm_pkg::ITM_IDLE) && (s_ff.count == 6'h00)
            && !$rose(s_ff.flag) && !slave_reset
    ) else $error("disabled monitor still active");

    start_arm_a: assert property (
        @(posedge mclk) disable iff (reset)
        (s_ff.state == itm_pkg::ITM_IDLE) && start_det && s_ff.en
        |=> (s_ff.state == itm_pkg::ITM_ARMED)
    ) else $error("START with the monitor enabled did not arm it");

    sts_sticky_a: assert property (
        @(posedge mclk) disable iff (reset)
        s_ff.sts[`ITM_STS_TO_BIT] && !sts_wr |=> s_ff.sts[`ITM_STS_TO_BIT]
    ) else $error("time-out status dropped without software");

endmodule

// *** sim/itm_bus_master.sv ***
module itm_bus_master (
    // Clock
    input  wire logic mclk,
    // Bus lines; released means high through the pull-up
    output logic      scl,
    output logic      sda
);
    timeunit 1ns;
    timeprecision 1ns;

    initial begin
        scl = 1'b1;
        sda = 1'b1;
    end

    task automatic hold(input int n);
        repeat (n) @(posedge mclk);
    endtask

    // Returns at the edge that drops SCL
    task automatic bus_start();
        hold(1);
        sda <= 1'b0;
        hold(8);
        scl <= 1'b0;
    endtask

    // Low phase of n cycles, high phase of 8; returns at the falling edge
    task automatic scl_pulse(input int n);
        hold(n);
        scl <= 1'b1;
        hold(8);
        scl <= 1'b0;
    endtask

    // Also frees a bus left with SCL stuck low
    task automatic bus_stop();
        hold(8);
        sda <= 1'b0;
        hold(8);
        scl <= 1'b1;
        hold(8);
        sda <= 1'b1;
    endtask
endmodule

// *** sim/test_i2c_slave_timeout_monitor.sv ***
module test_i2c_slave_timeout_monitor;
    timeunit 1ns;
    timeprecision 1ns;

    // ----------------
    // Signals
    // ----------------
    logic       mclk;
    logic       reset;
    logic       scl;
    logic       sda;
    logic       sub_clk;
    logic       addr_match;
    logic [3:0] addr;
    logic [7:0] wdata;
    logic       wr_strobe;
    logic       rd_strobe;
    logic [7:0] rdata;
    logic       slave_reset;
    logic [7:0] slave_status_control;
    logic       timeout_active;
    logic       irq;
    int         mismatches;
    int         checked;
    int         ctrl_m;
    int         sts_m;
    int         mask_m;
    int         slv_m;

    itm_bus_master itm_bus_master_i (.mclk(mclk), .scl(scl), .sda(sda));

    itm_timeout_monitor itm_timeout_monitor_i (
        .mclk(mclk), .reset(reset), .scl_in(scl), .sda_in(sda), .sub_clk_in(sub_clk),
        .addr_match(addr_match), .addr(addr), .wdata(wdata), .wr_strobe(wr_strobe),
        .rd_strobe(rd_strobe), .rdata(rdata), .slave_reset(slave_reset),
        .slave_status_control(slave_status_control), .timeout_active(timeout_active),
        .irq(irq));

    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    // Sub clock of 80 ns, phase unrelated to mclk
    initial begin
        sub_clk = 1'b0;
        #3;
        forever #40 sub_clk = ~sub_clk;
    end

    // ----------------
    // Compare tasks
    // ----------------
    task automatic cmp_reg(input logic [7:0] got, input logic [7:0] exp, input string what);
        checked++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected at %0t: %s is %h, model %h", $time, what, got, exp);
        end
    endtask

    task automatic cmp_pin(input logic got, input logic exp, input string what);
        checked++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected at %0t: %s is %b, model %b", $time, what, got, exp);
        end
    endtask

    task automatic cmp_time(input int n, input int lo, input int hi);
        checked++;
        if (n < lo || n > hi) begin
            mismatches++;
            $display("unexpected at %0t: expiry after %0d cycles, model %0d..%0d",
                     $time, n, lo, hi);
        end
    endtask

    task automatic stop_test();
        $display("comparisons %0d, mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // ----------------
    // Register port and model
    // ----------------
    function automatic logic [7:0] model_reg(input logic [3:0] a);
        case (a)
            4'h0: return 8'(ctrl_m);
            4'h1: return 8'(sts_m);
            4'h2: return 8'(mask_m);
            4'h3: return 8'(slv_m);
            default: return 8'h00;
        endcase
    endfunction

    task automatic reg_wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge mclk);
        addr <= a;
        wdata <= d;
        wr_strobe <= 1'b1;
        @(posedge mclk);
        wr_strobe <= 1'b0;
        case (a)
            4'h0: ctrl_m = d;
            4'h1: sts_m = sts_m & ~int'(d);
            4'h2: mask_m = d & 8'h03;
            4'h3: slv_m = d;
            default: ;
        endcase
    endtask

    logic [3:0] model_reg_addr [5] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h9};

    // Every read also checks irq and the slave control copy
    task automatic check_all();
        foreach (model_reg_addr[k]) begin
            @(posedge mclk);
            addr <= model_reg_addr[k];
            rd_strobe <= 1'b1;
            @(posedge mclk);
            rd_strobe <= 1'b0;
            #1;
            cmp_reg(rdata, model_reg(model_reg_addr[k]), "register");
            cmp_pin(irq, (sts_m & mask_m) != 0, "irq");
            cmp_reg(slave_status_control, 8'(slv_m), "slave control");
        end
    endtask

    // START, then an address match a few cycles later
    task automatic arm();
        itm_bus_master_i.bus_start();
        sts_m |= 2;
        repeat (6) @(posedge mclk);
        addr_match <= 1'b1;
        @(posedge mclk);
        addr_match <= 1'b0;
        itm_bus_master_i.scl_pulse(8);
    endtask

    // ----------------
    // Scenarios
    // ----------------
    task automatic run_timeout(input int sel, input logic [7:0] msk);
        int n;
        int lim;
        lim = (sel + 1) * 256;
        reg_wr(4'h2, msk);
        reg_wr(4'h3, 8'($urandom));
        reg_wr(4'h0, 8'h80 | 8'(sel));
        arm();
        // Falls spaced just inside the period keep it alive
        repeat (2) itm_bus_master_i.scl_pulse(lim - 48);
        cmp_pin(timeout_active, 1'b1, "running");
        @(posedge mclk);
        addr <= 4'h0;
        rd_strobe <= 1'b1;
        @(posedge mclk);
        rd_strobe <= 1'b0;
        #1;
        cmp_reg(rdata, model_reg(4'h0), "no expiry yet");
        n = 0;
        while (slave_reset !== 1'b1 && n < lim + 40) begin
            @(posedge mclk);
            #1;
            n++;
        end
        cmp_time(n, lim - 12, lim + 20);
        if (n >= lim + 40) begin
            stop_test();
        end
        ctrl_m = (ctrl_m & 8'h3F) | 8'h40;
        sts_m |= 1;
        slv_m = 0;
        @(posedge mclk);
        #1;
        cmp_pin(slave_reset, 1'b0, "slave reset pulse");
        cmp_pin(timeout_active, 1'b0, "halted");
        check_all();
        itm_bus_master_i.bus_stop();
        reg_wr(4'h1, 8'h03);
        check_all();
        reg_wr(4'h0, 8'h00);
        check_all();
        $display("test expiry sel %0d done at %0t", sel, $time);
    endtask

    initial begin
        reset = 1'b1;
        addr_match = 1'b0;
        addr = 4'h0;
        wdata = 8'h00;
        wr_strobe = 1'b0;
        rd_strobe = 1'b0;
        mismatches = 0;
        checked = 0;
        ctrl_m = 0;
        sts_m = 0;
        mask_m = 0;
        slv_m = 0;
        void'($urandom(32'h933D21B9));
        repeat (12) @(posedge mclk);
        reset <= 1'b0;
        check_all();
        reg_wr(4'h9, 8'hFF);
        check_all();
        $display("test reset values done at %0t", $time);

        // Disabled monitor ignores a stuck bus
        reg_wr(4'h2, 8'h03);
        arm();
        repeat (300) @(posedge mclk);
        cmp_pin(timeout_active, 1'b0, "disabled");
        check_all();
        itm_bus_master_i.bus_stop();
        reg_wr(4'h1, 8'h02);
        $display("test disabled done at %0t", $time);

        // STOP ends the watch before expiry
        reg_wr(4'h0, 8'h80);
        arm();
        cmp_pin(timeout_active, 1'b1, "armed");
        itm_bus_master_i.bus_stop();
        repeat (300) @(posedge mclk);
        cmp_pin(timeout_active, 1'b0, "stopped");
        check_all();
        reg_wr(4'h0, 8'h00);
        reg_wr(4'h1, 8'h03);
        $display("test stop done at %0t", $time);

        // Clearing the enable mid-transfer drops the watch
        reg_wr(4'h0, 8'h80);
        arm();
        reg_wr(4'h0, 8'h00);
        @(posedge mclk);
        #1;
        cmp_pin(timeout_active, 1'b0, "enable cleared");
        repeat (300) @(posedge mclk);
        check_all();
        itm_bus_master_i.bus_stop();
        reg_wr(4'h1, 8'h03);
        $display("test disable mid-run done at %0t", $time);

        run_timeout(0, 8'h01);
        run_timeout(63, 8'($urandom_range(3, 0)));
        run_timeout(int'($urandom_range(7, 1)), 8'h00);
        stop_test();
    end
endmodule
